// ==== hw/mbi_pkg.sv ====
// package: shared types and constants for the multiplexed bus interface
package mbi_pkg;
    localparam int MBI_AD_W = 16;
    localparam int MBI_BYTE_W = 8;
    localparam int MBI_REG_IDX_W = 4;
    localparam int MBI_REG_CNT = 16;
    localparam int MBI_WAIT_CYC = 2;
    localparam int MBI_STROBE_CYC = 3;
    localparam logic [MBI_REG_IDX_W-1:0] MBI_STATUS_IDX = 4'hf;
    localparam logic [MBI_AD_W-1:0] MBI_REG_RESET = 16'h0000;
    localparam logic [3:0] MBI_STAT_IO = 4'h2;
    localparam logic [3:0] MBI_STAT_IACK = 4'h5;
    localparam logic [3:0] MBI_STAT_REFRESH = 4'h1;
    localparam logic [3:0] MBI_STAT_INTERNAL = 4'h0;

    typedef struct packed {
        logic [MBI_AD_W-1:0] ad;
        logic addr_strobe_n;
        logic data_strobe_n;
        logic read_not_write;
        logic byte_not_word;
        logic chip_select_n;
        logic [3:0] status;
        logic irq_acknowledge_n;
        logic reset_n;
        logic grant_chain_in_n;
    } mbi_bus_in_t;

    typedef struct packed {
        logic [MBI_AD_W-1:0] ad_out;
        logic ad_lo_oe;
        logic ad_hi_oe;
        logic wait_n_oe;
        logic irq_n_oe;
        logic mastership_request_n_oe;
        logic grant_chain_out_n;
        logic [MBI_AD_W-1:0] addr_out;
        logic addr_oe;
        logic addr_strobe_n;
        logic data_strobe_n;
        logic read_not_write;
        logic byte_not_word;
        logic bus_oe;
    } mbi_bus_out_t;
endpackage

// ==== hw/mbi_sync.sv ====
// module: two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mbi_sync #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic [W-1:0] async_in,
    input wire logic [W-1:0] reset_val_in,
    input wire logic rst_n_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } mbi_sync_state_t;
    mbi_sync_state_t st;
    mbi_sync_state_t next_st;

    always_comb begin
        next_st.first = async_in;
        next_st.second = st.first;
        if (!rst_n_in) begin
            next_st.first = reset_val_in;
            next_st.second = reset_val_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

    assign sync_out = st.second;
endmodule
`default_nettype wire

// ==== hw/mbi_regfile.sv ====
// module: small register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module mbi_regfile (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [mbi_pkg::MBI_REG_IDX_W-1:0] addr_in,
    input wire logic [mbi_pkg::MBI_AD_W-1:0] wr_data_in,
    input wire logic [1:0] wr_lanes_in,
    output logic [mbi_pkg::MBI_AD_W-1:0] rd_data_out
);
    import mbi_pkg::*;
    typedef struct packed {
        logic [MBI_REG_CNT-1:0][MBI_AD_W-1:0] mem;
        logic [MBI_AD_W-1:0] rd;
    } mbi_rf_state_t;
    mbi_rf_state_t st;
    mbi_rf_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.rd = st.mem[addr_in];
        if (wr_en_in) begin
            if (wr_lanes_in[0]) begin
                next_st.mem[addr_in][MBI_BYTE_W-1:0] = wr_data_in[MBI_BYTE_W-1:0];
            end
            if (wr_lanes_in[1]) begin
                next_st.mem[addr_in][MBI_AD_W-1:MBI_BYTE_W] = wr_data_in[MBI_AD_W-1:MBI_BYTE_W];
            end
        end
        if (!rst_n_in) begin
            next_st.mem = {MBI_REG_CNT{MBI_REG_RESET}};
            next_st.rd = MBI_REG_RESET;
        end
    end

    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

    assign rd_data_out = st.rd;
endmodule
`default_nettype wire

// ==== hw/mbi_device.sv ====
// module: peripheral and requester end of the multiplexed address/data bus
`timescale 1ns/100ps
`default_nettype none
module mbi_device #(
    parameter bit WIDE_DEVICE = 1'b1,
    parameter bit RESET_ON_CHAIN = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire mbi_pkg::mbi_bus_in_t bus_in,
    input wire logic mastership_request_n_in,
    input wire logic irq_event_in,
    input wire logic irq_clear_in,
    input wire logic [mbi_pkg::MBI_BYTE_W-1:0] irq_vector_in,
    input wire logic dma_req_in,
    input wire logic [mbi_pkg::MBI_AD_W-1:0] dma_addr_in,
    input wire logic [mbi_pkg::MBI_AD_W-1:0] dma_wdata_in,
    input wire logic dma_write_in,
    output mbi_pkg::mbi_bus_out_t bus_out,
    output logic dma_done_out,
    output logic dma_busy_out,
    output logic [mbi_pkg::MBI_AD_W-1:0] dma_rdata_out,
    output logic irq_pending_out,
    output logic bus_reset_out
);
    import mbi_pkg::*;

    typedef enum {
        M_IDLE,
        M_REQ,
        M_ADDR,
        M_LATCH,
        M_DATA,
        M_END
    } mbi_mstate_t;

    typedef struct packed {
        logic sel;
        logic rd;
        logic byte_xfer;
        logic io;
        logic iack;
        logic null_xfer;
        logic [MBI_REG_IDX_W-1:0] idx;
        logic as_q;
        logic ds_q;
        logic data_seen;
        logic [1:0] wait_cnt;
        logic drive;
        logic [MBI_AD_W-1:0] dout;
        logic irq_pend;
        logic under_service;
        logic iack_sel;
        mbi_mstate_t mstate;
        logic mastered;
        logic [1:0] phase_cnt;
        logic [MBI_AD_W-1:0] rdata;
        logic done;
    } mbi_state_t;

    mbi_state_t st;
    mbi_state_t next_st;
    mbi_bus_in_t bs;
    logic req_s;
    logic strobe_reset;
    logic chain_reset;
    logic any_reset;
    logic rf_wr;
    logic [1:0] rf_lanes;
    logic [MBI_AD_W-1:0] rf_rd;
    logic [MBI_AD_W-1:0] rf_wdata;

    function automatic logic [MBI_AD_W-1:0] mbi_lane_in(input logic [MBI_AD_W-1:0] ad,
                                                        input logic byte_xfer, input logic wide);
        // upper lines may still hold address when data is a byte
        // upper ignored
        if (byte_xfer || !wide) begin
            mbi_lane_in = {{MBI_BYTE_W{1'b0}}, ad[MBI_BYTE_W-1:0]};
        end else begin
            mbi_lane_in = ad;
        end
    endfunction

    mbi_sync #(
        .W($bits(mbi_bus_in_t) + 1)
    ) u_sync (
        .mclk_in(mclk_in),
        .async_in({bus_in, mastership_request_n_in}),
        .reset_val_in({{MBI_AD_W{1'b0}}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1}),
        .rst_n_in(rst_n_in),
        .sync_out({bs, req_s})
    );

    assign strobe_reset = !bs.addr_strobe_n && !bs.data_strobe_n;
    assign chain_reset = RESET_ON_CHAIN && strobe_reset && bs.grant_chain_in_n;
    assign any_reset = !rst_n_in || !bs.reset_n || strobe_reset || chain_reset;

    mbi_regfile u_regs (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(rf_wr),
        .addr_in(st.idx),
        .wr_data_in(rf_wdata),
        .wr_lanes_in(rf_lanes),
        .rd_data_out(rf_rd)
    );

    always_comb begin
        logic as_rise;
        logic ds_fall;
        logic ds_rise;
        logic slave_idle;
        as_rise = 1'b0;
        ds_fall = 1'b0;
        ds_rise = 1'b0;
        slave_idle = 1'b1;
        next_st = st;
        rf_wr = 1'b0;
        rf_lanes = 2'b00;
        rf_wdata = mbi_lane_in(bs.ad, st.byte_xfer, WIDE_DEVICE);
        next_st.as_q = bs.addr_strobe_n;
        next_st.ds_q = bs.data_strobe_n;
        next_st.done = 1'b0;
        as_rise = !st.as_q && bs.addr_strobe_n;
        ds_fall = st.ds_q && !bs.data_strobe_n;
        ds_rise = !st.ds_q && bs.data_strobe_n;
        slave_idle = (st.mstate == M_IDLE);

        if (irq_event_in) begin
            next_st.irq_pend = 1'b1;
        end else if (irq_clear_in) begin
            next_st.irq_pend = 1'b0;
            next_st.under_service = 1'b0;
        end

        if (as_rise && slave_idle) begin
            next_st.sel = !bs.chip_select_n;
            next_st.rd = bs.read_not_write;
            next_st.byte_xfer = bs.byte_not_word || !WIDE_DEVICE;
            next_st.io = (bs.status == MBI_STAT_IO);
            next_st.iack = !bs.irq_acknowledge_n || (bs.status == MBI_STAT_IACK);
            next_st.null_xfer = (bs.status == MBI_STAT_REFRESH) || (bs.status == MBI_STAT_INTERNAL);
            next_st.idx = bs.ad[MBI_REG_IDX_W-1:0];
            next_st.data_seen = 1'b0;
            next_st.wait_cnt = (bs.status == MBI_STAT_IO) ? 2'(MBI_WAIT_CYC) : 2'(MBI_WAIT_CYC - 1);
            next_st.iack_sel = !bs.grant_chain_in_n && st.irq_pend && !st.under_service;
        end

        if (!bs.data_strobe_n && st.wait_cnt != 2'h0) begin
            next_st.wait_cnt = st.wait_cnt - 2'h1;
        end

        if (ds_fall && !st.null_xfer) begin
            next_st.data_seen = 1'b1;
            if (st.iack && st.iack_sel) begin
                next_st.under_service = 1'b1;
                next_st.dout = {{MBI_BYTE_W{1'b0}}, irq_vector_in};
            end else if (st.sel && st.rd) begin
                next_st.dout = (st.idx == MBI_STATUS_IDX) ?
                    {{(MBI_AD_W-2){1'b0}}, st.under_service, st.irq_pend} : rf_rd;
            end
        end
        if (ds_rise && st.sel && !st.rd && !st.null_xfer && !st.iack) begin
            rf_wr = 1'b1;
            rf_lanes = st.byte_xfer ? 2'b01 : 2'b11;
        end
        next_st.drive = !bs.data_strobe_n && !st.null_xfer &&
                        ((st.sel && st.rd) || (st.iack && st.iack_sel));

        case (st.mstate)
            M_IDLE: begin
                if (dma_req_in) begin
                    next_st.mstate = M_REQ;
                end
            end
            M_REQ: begin
                if (!bs.grant_chain_in_n) begin
                    next_st.mstate = M_ADDR;
                    next_st.mastered = 1'b1;
                    next_st.phase_cnt = 2'(MBI_STROBE_CYC - 1);
                    // stale slave select would answer our own strobes
                    next_st.sel = 1'b0;
                    next_st.iack = 1'b0;
                    next_st.iack_sel = 1'b0;
                end
            end
            M_ADDR: begin
                // strobes last long enough for two-flop receivers
                if (st.phase_cnt != 2'h0) begin
                    next_st.phase_cnt = st.phase_cnt - 2'h1;
                end else begin
                    next_st.mstate = M_LATCH;
                end
            end
            M_LATCH: begin
                next_st.mstate = M_DATA;
                next_st.phase_cnt = 2'(MBI_STROBE_CYC - 1);
            end
            M_DATA: begin
                // no wait input here, so the strobe length is fixed
                if (st.phase_cnt != 2'h0) begin
                    next_st.phase_cnt = st.phase_cnt - 2'h1;
                end else begin
                    next_st.mstate = M_END;
                    next_st.rdata = mbi_lane_in(bs.ad, 1'b0, WIDE_DEVICE);
                end
            end
            M_END: begin
                next_st.mstate = M_IDLE;
                next_st.mastered = 1'b0;
                next_st.done = 1'b1;
            end
            default: begin
                next_st.mstate = M_IDLE;
            end
        endcase

        if (any_reset) begin
            next_st = '0;
            next_st.as_q = 1'b1;
            next_st.ds_q = 1'b1;
            next_st.mstate = M_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        st <= next_st;
    end

    always_comb begin
        bus_out = '0;
        bus_out.ad_out = st.dout;
        bus_out.ad_lo_oe = st.drive;
        bus_out.ad_hi_oe = st.drive && WIDE_DEVICE && !st.byte_xfer && !st.iack;
        bus_out.wait_n_oe = st.sel && !st.null_xfer && !bs.data_strobe_n && (st.wait_cnt != 2'h0);
        bus_out.irq_n_oe = st.irq_pend && !st.under_service && !st.iack;
        bus_out.mastership_request_n_oe = (st.mstate != M_IDLE);
        bus_out.grant_chain_out_n = (st.mstate == M_REQ || st.mastered) ? 1'b1 : bs.grant_chain_in_n;
        bus_out.bus_oe = st.mastered;
        bus_out.addr_out = dma_addr_in;
        bus_out.addr_oe = st.mastered && (st.mstate == M_ADDR) || (st.mastered && !dma_write_in ? 1'b0 :
                          st.mastered && st.mstate == M_DATA);
        bus_out.addr_strobe_n = !(st.mstate == M_ADDR);
        bus_out.data_strobe_n = !(st.mstate == M_DATA);
        bus_out.read_not_write = !dma_write_in;
        bus_out.byte_not_word = !WIDE_DEVICE;
        if (st.mstate == M_DATA && dma_write_in) begin
            bus_out.addr_out = dma_wdata_in;
        end
    end

    assign dma_done_out = st.done;
    assign dma_busy_out = st.mastered;
    assign dma_rdata_out = st.rdata;
    assign irq_pending_out = st.irq_pend;
    assign bus_reset_out = any_reset;
endmodule
`default_nettype wire

// ==== testbench/mbi_device_properties.sv ====
// checker: port properties of the bus device end
`timescale 1ns/100ps
`default_nettype none
module mbi_device_properties (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire mbi_pkg::mbi_bus_in_t bus_in,
    input wire logic dma_req_in,
    input wire mbi_pkg::mbi_bus_out_t bus_out,
    input wire logic dma_done_out,
    input wire logic bus_reset_out
);
    import mbi_pkg::*;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // pins pass two sync flops, hence the run lengths
    reset_pin_a: assert property (!bus_in.reset_n [*4] |-> bus_reset_out)
        else $error("reset pin not honoured");
    strobe_reset_a: assert property ((!bus_in.addr_strobe_n && !bus_in.data_strobe_n) [*4] |-> bus_reset_out)
        else $error("strobe overlap not honoured");
    read_release_a: assert property (bus_in.data_strobe_n [*5] ##0 !bus_out.bus_oe |->
        !(bus_out.ad_lo_oe || bus_out.ad_hi_oe))
        else $error("data lines driven with strobe high");
    lane_order_a: assert property (!bus_out.bus_oe && bus_out.ad_hi_oe |-> bus_out.ad_lo_oe)
        else $error("upper lane driven alone");
    chain_pass_a: assert property (bus_in.grant_chain_in_n [*4] |-> bus_out.grant_chain_out_n)
        else $error("grant passed without grant in");
    no_grant_master_a: assert property (bus_in.grant_chain_in_n [*8] |-> !bus_out.bus_oe)
        else $error("bus driven without grant");
    request_pull_a: assert property ($rose(dma_req_in) |-> ##[1:4] bus_out.mastership_request_n_oe)
        else $error("request line not pulled");
    done_pulse_a: assert property (dma_done_out |=> !dma_done_out)
        else $error("done longer than one cycle");
    no_overlap_a: assert property (bus_out.bus_oe |-> bus_out.addr_strobe_n || bus_out.data_strobe_n)
        else $error("master drove both strobes low");
    ds_width_a: assert property (bus_out.bus_oe && $fell(bus_out.data_strobe_n) |->
        !bus_out.data_strobe_n [*3])
        else $error("data strobe too short");
    cover property (bus_out.bus_oe && !bus_out.addr_strobe_n);
    cover property (bus_reset_out);
    cover property (bus_out.ad_lo_oe && !bus_out.bus_oe);
endmodule
bind mbi_device mbi_device_properties mbi_device_properties_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .bus_in(bus_in), .dma_req_in(dma_req_in), .bus_out(bus_out), .dma_done_out(dma_done_out),
    .bus_reset_out(bus_reset_out));
`default_nettype wire

// ==== testbench/mbi_master_model.sv ====
// model: bus master that frames transfers and grants the bus
`timescale 1ns/100ps
`default_nettype none
module mbi_master_model (
    input wire logic mclk_in,
    input wire mbi_pkg::mbi_bus_out_t dev_in,
    output mbi_pkg::mbi_bus_in_t bus_out,
    output logic rd_valid_out,
    output logic [mbi_pkg::MBI_AD_W-1:0] rd_data_out
);
    import mbi_pkg::*;
    mbi_bus_in_t drv = '{ad: 16'h0000, status: 4'h0, default: 1'b1};
    logic busy = 1'b0;
    initial rd_valid_out = 1'b0;
    initial rd_data_out = '0;
    // no extended address lines on this bus
    // wire level: whoever enables a lane wins it
    always_comb begin
        bus_out = drv;
        if (dev_in.bus_oe) begin
            bus_out.addr_strobe_n = dev_in.addr_strobe_n;
            bus_out.data_strobe_n = dev_in.data_strobe_n;
            bus_out.read_not_write = dev_in.read_not_write;
            bus_out.byte_not_word = dev_in.byte_not_word;
        end
        if (dev_in.ad_lo_oe) bus_out.ad[7:0] = dev_in.ad_out[7:0];
        if (dev_in.ad_hi_oe) bus_out.ad[15:8] = dev_in.ad_out[15:8];
    end
    always @(posedge mclk_in) begin
        #1;
        drv.grant_chain_in_n = !(dev_in.mastership_request_n_oe === 1'b1 && !busy);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic xfer(input logic rnw, bnw, cs_n, ds_on, input logic [3:0] st, input logic [15:0] a, d);
        tick(1);
        busy = 1'b1;
        drv.status = st;
        drv.read_not_write = rnw;
        drv.byte_not_word = bnw;
        drv.chip_select_n = cs_n;
        drv.ad = a;
        drv.addr_strobe_n = 1'b0;
        tick(3);
        drv.addr_strobe_n = 1'b1;
        tick(3);
        // address kept on upper lines for byte writes
        drv.ad = rnw ? ~a : (bnw ? {a[15:8], d[7:0]} : d);
        // strobe times data or stays high
        drv.data_strobe_n = !ds_on;
        tick(6);
        // stretch while the slave holds wait
        for (int i = 0; i < 40 && dev_in.wait_n_oe === 1'b1; i++) tick(1);
        rd_data_out = bnw ? {8'h00, bus_out.ad[7:0]} : bus_out.ad;
        rd_valid_out = rnw && ds_on;
        drv.data_strobe_n = 1'b1;
        tick(1);
        rd_valid_out = 1'b0;
        drv.ad = ~drv.ad;
        tick(2);
        busy = 1'b0;
    endtask
    task automatic hold(input logic pin_n, strobes_n);
        tick(1);
        drv.reset_n = pin_n;
        drv.addr_strobe_n = strobes_n;
        drv.data_strobe_n = strobes_n;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: master model against the device end
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mbi_pkg::*;
    logic mclk_in, rst_n_in, dma_req_in, dma_done_out, dma_busy_out, irq_pending_out, bus_reset_out, rd_valid;
    logic [MBI_AD_W-1:0] dma_addr_in, dma_wdata_in, dma_rdata_out, rd_data, v;
    logic [3:0] idx;
    mbi_bus_in_t pin_bus;
    mbi_bus_out_t dev_bus;
    logic [MBI_AD_W-1:0] exp_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int seed = 32'h3012;
    int k;
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    mbi_device mbi_device_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(pin_bus),
        .mastership_request_n_in(!dev_bus.mastership_request_n_oe), .irq_event_in(1'b0), .irq_clear_in(1'b0),
        .irq_vector_in(8'h00), .dma_req_in(dma_req_in), .dma_addr_in(dma_addr_in), .dma_wdata_in(dma_wdata_in),
        .dma_write_in(1'b1), .bus_out(dev_bus), .dma_done_out(dma_done_out), .dma_busy_out(dma_busy_out),
        .dma_rdata_out(dma_rdata_out), .irq_pending_out(irq_pending_out), .bus_reset_out(bus_reset_out));
    mbi_master_model mbi_master_model_inst (.mclk_in(mclk_in), .dev_in(dev_bus), .bus_out(pin_bus),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data));
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(input logic bnw, cs_n, ds_on, input logic [3:0] st, i, input logic [15:0] d);
        mbi_master_model_inst.xfer(1'b0, bnw, cs_n, ds_on, st, {12'h5a0, i}, d);
    endtask
    task automatic rd(input logic bnw, input logic [3:0] i, input logic [15:0] e);
        exp_q.push_back(e);
        mbi_master_model_inst.xfer(1'b1, bnw, 1'b0, 1'b1, MBI_STAT_IO, {12'h5a0, i}, 16'h0000);
    endtask
    always @(posedge mclk_in) begin
        if (rd_valid === 1'b1) begin
            check("read data", rd_data, exp_q.pop_front());
        end
    end
    initial begin
        rst_n_in = 1'b0;
        dma_req_in = 1'b0;
        dma_addr_in = 16'h0040;
        dma_wdata_in = 16'h0000;
        // three edges flush the pin synchronisers
        tick(3);
        rst_n_in = 1'b1;
        tick(3);
        check("grant out idle", {15'h0, dev_bus.grant_chain_out_n}, 16'h0001);
        wr(1'b0, 1'b0, 1'b1, MBI_STAT_IO, 4'h3, 16'hbeef);
        rd(1'b0, 4'h3, 16'hbeef);
        rd(1'b1, 4'h3, 16'h00ef);
        v = 16'($random(seed));
        wr(1'b1, 1'b0, 1'b1, MBI_STAT_IO, 4'h4, v);
        rd(1'b0, 4'h4, {MBI_REG_RESET[15:8], v[7:0]});
        wr(1'b0, 1'b1, 1'b1, MBI_STAT_IO, 4'h5, 16'hffff);
        rd(1'b0, 4'h5, MBI_REG_RESET);
        wr(1'b0, 1'b0, 1'b1, MBI_STAT_REFRESH, 4'h6, 16'h1111);
        wr(1'b0, 1'b0, 1'b1, MBI_STAT_INTERNAL, 4'h6, 16'h2222);
        wr(1'b0, 1'b0, 1'b0, MBI_STAT_IO, 4'h6, 16'h3333);
        rd(1'b0, 4'h6, MBI_REG_RESET);
        for (k = 0; k < 8; k++) begin
            idx = 4'(($unsigned($random(seed)) % 7) + 8);
            v = 16'($random(seed));
            wr(1'b0, 1'b0, 1'b1, MBI_STAT_IO, idx, v);
            rd(1'b0, idx, v);
        end
        mbi_master_model_inst.hold(1'b1, 1'b0);
        tick(5);
        check("strobe reset", {15'h0, bus_reset_out}, 16'h0001);
        mbi_master_model_inst.hold(1'b0, 1'b1);
        tick(5);
        check("pin reset", {15'h0, bus_reset_out}, 16'h0001);
        mbi_master_model_inst.hold(1'b1, 1'b1);
        tick(5);
        check("reset released", {15'h0, bus_reset_out}, 16'h0000);
        dma_wdata_in = 16'($random(seed));
        dma_req_in = 1'b1;
        for (k = 0; k < 300 && dma_done_out !== 1'b1; k++) tick(1);
        check("dma done", {15'h0, dma_done_out}, 16'h0001);
        if (k == 300) give_verdict();
        dma_req_in = 1'b0;
        tick(10);
        check("grant returned", {15'h0, pin_bus.grant_chain_in_n}, 16'h0001);
        give_verdict();
    end
endmodule
`default_nettype wire
